//--- src/scdl_pkg.sv
// Purpose: Shared constants and types for the serial current converter loader
// Assumes: 16-bit serial word, 4-bit address field, 12-bit code
// Notes: Timing counts derive from the system clock rate
package scdl_pkg;
  localparam int WORD_BITS = 16;
  localparam int CODE_BITS = 12;
  localparam int ADDR_BITS = 4;
  localparam int STRAP_BITS = 3;
  localparam logic [CODE_BITS-1:0] CODE_RESET = 12'h000;
  localparam logic [WORD_BITS-1:0] WORD_RESET = 16'h0000;
  localparam logic ADDR_TOP_REQ = 1'b0;
  localparam int CLK_PERIOD_NS = 100;
  localparam int RESTORE_TIME_US = 6;
  // Longest time rounds down, at least one cycle
  localparam int RESTORE_CYCLES_RAW = (RESTORE_TIME_US * 1000) / CLK_PERIOD_NS;
  localparam int RESTORE_CYCLES = (RESTORE_CYCLES_RAW < 1) ? 1 : RESTORE_CYCLES_RAW;
  localparam int RESTORE_W = $clog2(RESTORE_CYCLES + 1);

  typedef struct packed {
    logic [ADDR_BITS-1:0] addr;
    logic [CODE_BITS-1:0] code;
  } scdl_word_type;

  typedef enum logic [1:0] {
    SCDL_OFF,
    SCDL_WAKE,
    SCDL_ON
  } scdl_out_state_type;
endpackage

//--- src/scdl_shifter.sv
// Purpose: Serial-clock side shift register and word capture
// Assumes: Serial clock stops or runs freely; chip select is active low
// Notes: Word capture is handed over with a toggle
`timescale 1ns/1ps
module scdl_shifter
  import scdl_pkg::*;
(
  input wire logic sclk_in,
  input wire logic arst_n_in,
  input wire logic cs_n_in,
  input wire logic sdi_in,
  output scdl_pkg::scdl_word_type word_out,
  output logic cap_toggle_out
);
  import scdl_pkg::*;

  logic [WORD_BITS-1:0] shreg;
  logic [WORD_BITS-1:0] next_shreg;

  always_comb
  begin
    next_shreg = shreg;
    if (!cs_n_in)
    begin
      // Shift in at rising edge, oldest bit drops out
      next_shreg = {shreg[WORD_BITS-2:0], sdi_in};
    end
    // Edges while deselected leave the word alone
  end

  always_ff @(posedge sclk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      shreg <= WORD_RESET;
    end
    else
    begin
      shreg <= next_shreg;
    end
  end

  // Chip select rising edge captures the word
  always_ff @(posedge cs_n_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      word_out <= WORD_RESET;
      cap_toggle_out <= 1'b0;
    end
    else
    begin
      word_out <= shreg;
      cap_toggle_out <= ~cap_toggle_out;
    end
  end
endmodule

//--- src/scdl_top.sv
// Purpose: Digital front end of a 12-bit current output converter
// Assumes: 10 MHz system clock; serial link on its own clock
// Notes: Analog stage and fault detection sit outside; fault arrives as a level
`timescale 1ns/1ps
module scdl_top
  import scdl_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic arst_n_in,
  input wire logic sclk_in,
  input wire logic cs_n_in,
  input wire logic sdi_in,
  input wire logic standby_n_in,
  input wire logic addr_strap_bit2_in,
  input wire logic addr_strap_bit1_in,
  input wire logic addr_strap_bit0_in,
  input wire logic load_fault_in,
  output logic [scdl_pkg::CODE_BITS-1:0] dac_code_out,
  output logic out_enable_out,
  output logic out_settled_out,
  output logic fault_out
);
  import scdl_pkg::*;

  scdl_word_type cap_word;
  logic cap_toggle;

  // Link side, kept by the host
  scdl_shifter u_shifter (
    .sclk_in(sclk_in),
    .arst_n_in(arst_n_in),
    .cs_n_in(cs_n_in),
    .sdi_in(sdi_in),
    .word_out(cap_word),
    .cap_toggle_out(cap_toggle)
  );

  // Synchronisers for toggle and pin levels
  logic [2:0] tog_sync;
  logic [1:0] sb_sync;
  logic [1:0] flt_sync;
  logic [STRAP_BITS-1:0] strap_s1;
  logic [STRAP_BITS-1:0] strap_s2;
  logic [2:0] next_tog_sync;
  logic [1:0] next_sb_sync;
  logic [1:0] next_flt_sync;
  logic [STRAP_BITS-1:0] next_strap_s1;
  logic [STRAP_BITS-1:0] next_strap_s2;

  always_comb
  begin
    next_tog_sync = {tog_sync[1:0], cap_toggle};
    next_sb_sync = {sb_sync[0], standby_n_in};
    next_flt_sync = {flt_sync[0], load_fault_in};
    next_strap_s1 = {addr_strap_bit2_in, addr_strap_bit1_in, addr_strap_bit0_in};
    next_strap_s2 = strap_s1;
  end

  always_ff @(posedge clk_sys_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      tog_sync <= 3'h0;
      sb_sync <= 2'h0;
      flt_sync <= 2'h0;
      strap_s1 <= 3'h0;
      strap_s2 <= 3'h0;
    end
    else
    begin
      tog_sync <= next_tog_sync;
      sb_sync <= next_sb_sync;
      flt_sync <= next_flt_sync;
      strap_s1 <= next_strap_s1;
      strap_s2 <= next_strap_s2;
    end
  end

  logic cap_event;
  logic standby_on;
  logic addr_match;

  assign cap_event = tog_sync[2] ^ tog_sync[1];
  assign standby_on = ~sb_sync[1];
  // Top address bit zero, remaining three equal straps
  assign addr_match = (cap_word.addr == {ADDR_TOP_REQ, strap_s2});

  // Code register; captured word is stable when toggle is seen
  logic [CODE_BITS-1:0] code;
  logic [CODE_BITS-1:0] next_code;

  always_comb
  begin
    next_code = code;
    if (cap_event && addr_match && !standby_on)
    begin
      next_code = cap_word.code;
    end
  end

  always_ff @(posedge clk_sys_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      code <= CODE_RESET;
    end
    else
    begin
      code <= next_code;
    end
  end

  // Output stage state
  scdl_out_state_type state;
  scdl_out_state_type next_state;
  logic [RESTORE_W-1:0] wake_cnt;
  logic [RESTORE_W-1:0] next_wake_cnt;
  logic next_out_enable;
  logic next_out_settled;

  always_comb
  begin
    next_state = state;
    next_wake_cnt = wake_cnt;
    unique case (state)
      SCDL_OFF:
      begin
        next_wake_cnt = '0;
        if (!standby_on)
        begin
          next_state = SCDL_WAKE;
        end
      end
      SCDL_WAKE:
      begin
        if (standby_on)
        begin
          next_state = SCDL_OFF;
        end
        else if (wake_cnt == RESTORE_W'(RESTORE_CYCLES - 1))
        begin
          next_state = SCDL_ON;
        end
        else
        begin
          next_wake_cnt = wake_cnt + RESTORE_W'(1);
        end
      end
      SCDL_ON:
      begin
        if (standby_on)
        begin
          next_state = SCDL_OFF;
        end
      end
    endcase
    next_out_enable = (next_state != SCDL_OFF);
    next_out_settled = (next_state == SCDL_ON);
  end

  always_ff @(posedge clk_sys_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      state <= SCDL_OFF;
      wake_cnt <= '0;
      out_enable_out <= 1'b0;
      out_settled_out <= 1'b0;
      dac_code_out <= CODE_RESET;
      fault_out <= 1'b0;
    end
    else
    begin
      state <= next_state;
      wake_cnt <= next_wake_cnt;
      out_enable_out <= next_out_enable;
      out_settled_out <= next_out_settled;
      // Code held through standby and kept on the output the whole time
      dac_code_out <= next_code;
      fault_out <= flt_sync[1];
    end
  end
endmodule

//--- sim/scdl_props.sv
// Purpose: Port timing checks for the loader
// Assumes: System clock domain only
// Notes: Latency bounds follow the designer's figures
`timescale 1ns/1ps
module scdl_props
  import scdl_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic arst_n_in,
  input wire logic sclk_in,
  input wire logic cs_n_in,
  input wire logic sdi_in,
  input wire logic standby_n_in,
  input wire logic addr_strap_bit2_in,
  input wire logic addr_strap_bit1_in,
  input wire logic addr_strap_bit0_in,
  input wire logic load_fault_in,
  input wire logic [scdl_pkg::CODE_BITS-1:0] dac_code_out,
  input wire logic out_enable_out,
  input wire logic out_settled_out,
  input wire logic fault_out
);
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!arst_n_in);
  sequence s_wake;
    $rose(standby_n_in) ##[1:4] out_enable_out;
  endsequence
  property p_rst;
    $rose(arst_n_in) |-> dac_code_out == CODE_RESET;
  endproperty
  property p_off;
    $fell(standby_n_in) |-> ##[1:4] !out_enable_out;
  endproperty
  property p_wake;
    s_wake |-> ##[1:64] out_settled_out;
  endproperty
  property p_dark;
    !out_enable_out |-> !out_settled_out;
  endproperty
  property p_idle;
    !standby_n_in [*6] |=> $stable(dac_code_out);
  endproperty
  property p_quiet;
    cs_n_in [*6] |=> $stable(dac_code_out);
  endproperty
  property p_hold;
    $fell(out_enable_out) |-> $stable(dac_code_out) [*8];
  endproperty
  property p_fault;
    $rose(load_fault_in) |-> ##[1:4] fault_out;
  endproperty
  a_rst: assert property (p_rst) else $error("code not cleared");
  a_off: assert property (p_off) else $error("output not disabled");
  a_wake: assert property (p_wake) else $error("output not restored");
  a_dark: assert property (p_dark) else $error("settled while disabled");
  a_idle: assert property (p_idle) else $error("load in standby");
  a_quiet: assert property (p_quiet) else $error("code moved while deselected");
  a_hold: assert property (p_hold) else $error("code lost in standby");
  a_fault: assert property (p_fault) else $error("fault not shown");
endmodule
bind scdl_top scdl_props u_scdl_props (.clk_sys_in, .arst_n_in, .sclk_in, .cs_n_in,
  .sdi_in, .standby_n_in, .addr_strap_bit2_in, .addr_strap_bit1_in, .addr_strap_bit0_in,
  .load_fault_in, .dac_code_out, .out_enable_out, .out_settled_out, .fault_out);

//--- sim/scdl_host.sv
// Purpose: Serial host model
// Assumes: Link clock 15 ns, idle low
// Notes: Idle data line shows the inverse of its last bit
`timescale 1ns/1ps
module scdl_host
(
  output logic sclk_out,
  output logic cs_n_out,
  output logic sdi_out
);
  initial
  begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    sdi_out = 1'b0;
  end
  // Low n bits of w, top first, then stray edges while deselected
  task automatic send(input logic [19:0] w, input int n);
    cs_n_out = 1'b0;
    for (int i = n - 1; i >= 0; i--)
    begin
      sdi_out = w[i];
      #7.5 sclk_out = 1'b1;
      #7.5 sclk_out = 1'b0;
    end
    #7.5 cs_n_out = 1'b1;
    for (int i = 0; i < 3; i++)
    begin
      sdi_out = ~sdi_out;
      #7.5 sclk_out = 1'b1;
      #7.5 sclk_out = 1'b0;
    end
  endtask
endmodule

//--- sim/testbench.sv
// Purpose: Self-checking bench for the loader
// Assumes: Host model drives the serial port
// Notes: Expected codes queue up, a monitor pops them
`timescale 1ns/1ps
module testbench;
  import scdl_pkg::*;
  logic clk_sys_in = 1'b0, arst_n_in = 1'b0, sclk_in, cs_n_in, sdi_in, standby_n_in = 1'b1;
  logic addr_strap_bit2_in = 1'b0, addr_strap_bit1_in = 1'b0, addr_strap_bit0_in = 1'b0;
  logic load_fault_in = 1'b0, out_enable_out, out_settled_out, fault_out;
  logic [CODE_BITS-1:0] dac_code_out, cur = 12'h000, c;
  logic [CODE_BITS-1:0] q[$];
  int err_total = 0;
  int n_compared = 0;
  always #50 clk_sys_in = ~clk_sys_in;
  scdl_host u_scdl_host (.sclk_out(sclk_in), .cs_n_out(cs_n_in), .sdi_out(sdi_in));
  scdl_top u_scdl_top (.clk_sys_in, .arst_n_in, .sclk_in, .cs_n_in, .sdi_in, .standby_n_in,
    .addr_strap_bit2_in, .addr_strap_bit1_in, .addr_strap_bit0_in, .load_fault_in,
    .dac_code_out, .out_enable_out, .out_settled_out, .fault_out);
  task automatic chk(input string nm, input logic [11:0] seen, input logic [11:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      err_total++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic load(input logic [19:0] w, input int n, input bit hit);
    if (hit && w[11:0] != cur)
    begin
      cur = w[11:0];
      q.push_back(cur);
    end
    u_scdl_host.send(w, n);
    repeat (8) @(negedge clk_sys_in);
  endtask
  task automatic summarize();
    $display("errors %0d compared %0d", err_total, n_compared);
    if (err_total == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  always @(dac_code_out)
  begin
    c = (q.size() > 0) ? q.pop_front() : ~dac_code_out;
    chk("code", dac_code_out, c);
  end
  initial
  begin
    #1_000_000;
    err_total++;
    summarize();
  end
  initial
  begin
    logic [2:0] s;
    logic [11:0] v;
    q.push_back(12'h000);
    v = $urandom(23);
    s = $urandom;
    @(posedge clk_sys_in);
    {addr_strap_bit2_in, addr_strap_bit1_in, addr_strap_bit0_in} <= s;
    repeat (3) @(posedge clk_sys_in);
    arst_n_in <= 1'b1;
    repeat (4) @(negedge clk_sys_in);
    for (int i = 0; i < 6; i++)
    begin
      v = (i == 0) ? 12'hfff : (i == 1) ? 12'h000 : 12'($urandom);
      load({5'h00, s, v}, 16, 1'b1);
    end
    load({5'h00, s ^ 3'h1, 12'h5a5}, 16, 1'b0);
    load({5'h01, s, 12'h5a5}, 16, 1'b0);
    load({5'h14, s, 12'h3c3}, 20, 1'b1);
    @(posedge clk_sys_in);
    standby_n_in <= 1'b0;
    repeat (5) @(negedge clk_sys_in);
    chk("enable", {11'h0, out_enable_out}, 12'h000);
    load({5'h00, s, 12'h777}, 16, 1'b0);
    @(posedge clk_sys_in);
    standby_n_in <= 1'b1;
    repeat (70) @(negedge clk_sys_in);
    chk("restore", {10'h0, out_enable_out, out_settled_out}, 12'h003);
    @(posedge clk_sys_in);
    load_fault_in <= 1'b1;
    repeat (5) @(negedge clk_sys_in);
    chk("fault", {11'h0, fault_out}, 12'h001);
    @(posedge clk_sys_in);
    load_fault_in <= 1'b0;
    cur = 12'h000;
    q.push_back(cur);
    arst_n_in <= 1'b0;
    #10 chk("reset", dac_code_out, 12'h000);
    load({5'h00, s, 12'h456}, 16, 1'b0);
    @(posedge clk_sys_in);
    arst_n_in <= 1'b1;
    repeat (4) @(negedge clk_sys_in);
    load({5'h00, s, 12'h9ab}, 16, 1'b1);
    chk("pending", 12'(q.size()), 12'h000);
    summarize();
  end
endmodule
